// ==== include/swt_pkg.sv ====
// Shared constants and types for the setup and waveform transfer block.
// Assumes a single 125 MHz instrument clock and synchronous active-high reset.
package swt_pkg;

  // Byte-wide message stream
  localparam int BYTE_W          = 8;
  // Front-panel setup image: 400 characters at most
  localparam int SET_MAX_CHARS   = 400;
  localparam int SET_CMD_COUNT   = 11;
  // Nonvolatile slots, numbered 1 through 16
  localparam int SLOT_COUNT      = 16;
  // Operator text area length
  localparam int TEXT_MAX_CHARS  = 24;
  // Curve record layout
  localparam int CURVE_ID_CHARS  = 25;
  localparam int COORD_W         = 10;
  localparam int MAX_POINTS      = 1024;
  localparam int BYTES_PER_POINT = 4;
  localparam int MAX_CURVE_BYTES = 4099;
  // Preamble: 17 label/value pairs, about 410 characters
  localparam int PRE_PAIRS       = 17;
  localparam int PRE_MAX_CHARS   = 410;
  // Fifo depth in the outgoing data path
  localparam int OUT_FIFO_DEPTH  = 16;
  // ASCII codes used by the parser
  localparam logic [7:0] CH_LF   = 8'h0A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_SP   = 8'h20;
  localparam logic [7:0] CH_QM   = 8'h3F;
  localparam logic [7:0] CH_CR   = 8'h0D;

  // Decoded command kinds
  typedef enum logic [7:0] {
    SWT_CMD_NONE  = 8'h00,
    SWT_CMD_SETQ  = 8'h01,
    SWT_CMD_SAVE  = 8'h02,
    SWT_CMD_RECL  = 8'h03,
    SWT_CMD_TEXT  = 8'h04,
    SWT_CMD_STORE = 8'h05,
    SWT_CMD_PREQ  = 8'h06,
    SWT_CMD_CURVQ = 8'h07,
    SWT_CMD_HORQ  = 8'h08
  } swt_cmd_t;

endpackage : swt_pkg

// ==== include/swt_stream_if.sv ====
// Valid/ready byte stream with a last marker between the engine and its fifo.
// Assumes both ends share sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface swt_stream_if #(parameter int W = 8);
  logic [W-1:0] data;   // Payload byte
  logic         last;   // Final byte of message
  logic         valid;  // Byte offered
  logic         ready;  // Byte accepted
  modport src (output data, output last, output valid, input ready);
  modport snk (input data, input last, input valid, output ready);
endinterface : swt_stream_if
`default_nettype wire

// ==== verilog/swt_fifo.sv ====
// Synchronous fifo with valid/ready on both sides.
// Assumes one clock, synchronous reset and a freezing clock enable.
`timescale 1ns/10ps
`default_nettype none
module swt_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [AW-1:0]    wr_reg, wr_next;
  logic [AW-1:0]    rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointer and count
  always_comb begin
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop  ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (clk_en) begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule : swt_fifo // swt_fifo
`default_nettype wire

// ==== verilog/swt_engine.sv ====
// Message engine for front-panel setup, operator text and waveform transfer.
// Assumes bus handshakes arrive on sys_clk; pins are pre-decoded bytes with EOI.
`timescale 1ns/10ps
`default_nettype none
module swt_engine import swt_pkg::*; #(
  parameter int NPTS_W = 11,
  parameter int FIFO_D = swt_pkg::OUT_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                         sys_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         clk_en,
  // Listener bytes from bus (parsed message)
  input  wire logic [swt_pkg::BYTE_W-1:0]   rx_data,
  input  wire logic                         rx_valid,
  input  wire logic                         rx_eoi,
  // Decoded command with argument
  input  wire swt_pkg::swt_cmd_t            cmd,
  input  wire logic [4:0]                   cmd_arg,
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  // Talker bytes to bus
  output logic [swt_pkg::BYTE_W-1:0]        tx_data,
  output logic                              tx_eoi,
  output logic                              tx_valid,
  input  wire logic                         tx_ready,
  // Front panel setup image, text and display
  input  wire logic [swt_pkg::BYTE_W-1:0]   panel_char,
  output logic [8:0]                        panel_idx,
  input  wire logic [8:0]                   panel_len,
  output logic                              panel_load,
  output logic [swt_pkg::BYTE_W-1:0]        text_char,
  output logic [4:0]                        text_idx,
  output logic                              text_we,
  output logic                              store_mode,
  // Preamble, horizontal and curve sources
  input  wire logic [swt_pkg::BYTE_W-1:0]   pre_char,
  input  wire logic [8:0]                   pre_len,
  input  wire logic [swt_pkg::BYTE_W-1:0]   hor_char,
  input  wire logic [8:0]                   hor_len,
  input  wire logic [swt_pkg::BYTE_W-1:0]   id_char,
  input  wire logic [swt_pkg::COORD_W-1:0]  pt_x,
  input  wire logic [swt_pkg::COORD_W-1:0]  pt_y,
  input  wire logic [NPTS_W-1:0]            pt_count,
  output logic [8:0]                        src_idx,
  output logic [NPTS_W-1:0]                 pt_idx,
  // Sequencer status, high in every state except idle
  output logic                              busy
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [6:0] {
    SWT_IDLE = 7'b000_0001,
    SWT_SEND = 7'b000_0010,
    SWT_CID  = 7'b000_0100,
    SWT_CNT  = 7'b000_1000,
    SWT_PTS  = 7'b001_0000,
    SWT_SUM  = 7'b010_0000,
    SWT_COPY = 7'b100_0000
  } swt_st_t;

  // Sign-fill first byte of a 10-bit coordinate
  function automatic logic [7:0] hi_byte(input logic [COORD_W-1:0] v);
    hi_byte = {{6{v[COORD_W-1]}}, v[COORD_W-1:COORD_W-2]};
  endfunction

  swt_st_t          st_reg, st_next;
  logic [12:0]      cnt_reg, cnt_next;        // Byte counter within a phase
  logic [8:0]       len_reg, len_next;        // Length of ASCII response
  logic [1:0]       src_reg, src_next;        // 0 setup, 1 preamble, 2 horizontal
  logic [7:0]       sum_reg, sum_next;        // Running checksum
  logic [3:0]       slot_reg, slot_next;      // Active slot
  logic             dir_reg, dir_next;        // Copy direction: 1 save
  logic [4:0]       tix_reg, tix_next;        // Text position
  logic             txt_reg, txt_next;        // Text message in progress
  logic             sto_reg, sto_next;        // Store mode latch
  logic [7:0]       slots [SLOT_COUNT][SET_MAX_CHARS]; // Nonvolatile slot image
  logic [15:0]      nbytes;                   // Point byte count
  logic [7:0]       pbyte;                    // Current point byte
  logic [7:0]       ob_data;
  logic             ob_last, ob_valid;

  swt_stream_if #(.W(8)) ob ();
  logic [8:0] f_out;

  ////////////////////////////////////////////////////////////////////////////
  // Byte count of point data, four bytes per point
  assign nbytes = 16'(pt_count) * 16'(BYTES_PER_POINT);
  assign pt_idx = NPTS_W'(cnt_reg >> 2);
  assign src_idx = cnt_reg[8:0];
  assign panel_idx = cnt_reg[8:0];
  assign cmd_ready = (st_reg == SWT_IDLE);
  assign busy = (st_reg != SWT_IDLE);
  assign store_mode = sto_reg;

  // Point byte select: x hi, x lo, y hi, y lo
  always_comb begin
    case (cnt_reg[1:0])
      2'd0:    pbyte = hi_byte(pt_x);
      2'd1:    pbyte = pt_x[7:0];
      2'd2:    pbyte = hi_byte(pt_y);
      default: pbyte = pt_y[7:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the transfer sequencer
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    len_next  = len_reg;
    src_next  = src_reg;
    sum_next  = sum_reg;
    slot_next = slot_reg;
    dir_next  = dir_reg;
    sto_next  = sto_reg;
    ob_data   = 8'h00;
    ob_last   = 1'b0;
    ob_valid  = 1'b0;
    panel_load = 1'b0;
    case (st_reg)
      SWT_IDLE: begin
        cnt_next = '0;
        sum_next = '0;
        if (cmd_valid) begin
          case (cmd)
            SWT_CMD_SETQ: begin  // Setup goes out from the live panel
              src_next = 2'd0;
              len_next = (panel_len > 9'(SET_MAX_CHARS)) ? 9'(SET_MAX_CHARS) : panel_len;
              st_next  = SWT_SEND;
            end
            SWT_CMD_PREQ: begin
              src_next = 2'd1;
              len_next = pre_len;
              st_next  = SWT_SEND;
            end
            SWT_CMD_HORQ: begin
              src_next = 2'd2;
              len_next = hor_len;
              st_next  = SWT_SEND;
            end
            SWT_CMD_CURVQ: begin
              st_next = SWT_CID;
            end
            SWT_CMD_SAVE, SWT_CMD_RECL: begin  // Slot 1..16 maps to 0..15
              if (cmd_arg >= 5'd1 && cmd_arg <= 5'(SLOT_COUNT)) begin
                slot_next = 4'(cmd_arg - 5'd1);
                dir_next  = (cmd == SWT_CMD_SAVE);
                st_next   = SWT_COPY;
              end
            end
            SWT_CMD_STORE: begin
              sto_next = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      SWT_SEND: begin  // One byte per character
        ob_valid = (len_reg != '0);
        ob_data  = (src_reg == 2'd0) ? panel_char : (src_reg == 2'd1) ? pre_char : hor_char;
        ob_last  = (cnt_reg[8:0] == len_reg - 9'd1);
        if (len_reg == '0) begin
          st_next = SWT_IDLE;
        end else if (ob.ready) begin
          cnt_next = cnt_reg + 13'd1;
          if (ob_last) begin
            st_next = SWT_IDLE;
          end
        end
      end
      SWT_CID: begin
        ob_valid = 1'b1;
        ob_data  = id_char;
        if (ob.ready) begin
          cnt_next = cnt_reg + 13'd1;
          if (cnt_reg == 13'(CURVE_ID_CHARS - 1)) begin
            cnt_next = '0;
            st_next  = SWT_CNT;
          end
        end
      end
      SWT_CNT: begin  // Count high byte then low
        ob_valid = 1'b1;
        ob_data  = cnt_reg[0] ? nbytes[7:0] : nbytes[15:8];
        if (ob.ready) begin
          sum_next = sum_reg + ob_data;
          cnt_next = cnt_reg + 13'd1;
          if (cnt_reg[0]) begin
            cnt_next = '0;
            st_next  = SWT_PTS;
          end
        end
      end
      SWT_PTS: begin
        ob_valid = 1'b1;
        ob_data  = pbyte;
        if (ob.ready) begin
          sum_next = sum_reg + pbyte;
          cnt_next = cnt_reg + 13'd1;
          if (cnt_reg == 13'(nbytes - 16'd1)) begin
            st_next = SWT_SUM;
          end
        end
      end
      SWT_SUM: begin
        ob_valid = 1'b1;
        ob_data  = sum_reg;
        ob_last  = 1'b1;
        if (ob.ready) begin
          st_next = SWT_IDLE;
        end
      end
      SWT_COPY: begin  // Slot traffic only touches the front panel
        panel_load = !dir_reg;
        cnt_next = cnt_reg + 13'd1;
        if (cnt_reg == 13'(SET_MAX_CHARS - 1)) begin
          st_next = SWT_IDLE;
        end
      end
      default: begin
        st_next = SWT_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg   <= SWT_IDLE;
      cnt_reg  <= '0;
      len_reg  <= '0;
      src_reg  <= '0;
      sum_reg  <= '0;
      slot_reg <= '0;
      dir_reg  <= 1'b0;
      sto_reg  <= 1'b0;
    end else if (clk_en) begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      len_reg  <= len_next;
      src_reg  <= src_next;
      sum_reg  <= sum_next;
      slot_reg <= slot_next;
      dir_reg  <= dir_next;
      sto_reg  <= sto_next;
    end
  end

  // Slot image write on save; recall only pulses panel_load, slot contents are never read out
  always_ff @(posedge sys_clk) begin
    if (clk_en && st_reg == SWT_COPY && dir_reg) begin
      slots[slot_reg][cnt_reg[8:0]] <= panel_char;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operator text capture; message ends on LF or EOI
  always_comb begin
    tix_next = tix_reg;
    txt_next = txt_reg;
    text_we  = 1'b0;
    text_char = rx_data;
    if (cmd_valid && cmd_ready && cmd == SWT_CMD_TEXT) begin
      txt_next = 1'b1;
      tix_next = '0;
    end else if (txt_reg && rx_valid) begin
      if (rx_data == CH_LF) begin
        txt_next = 1'b0;
      end else begin
        text_we  = (tix_reg < 5'(TEXT_MAX_CHARS));
        tix_next = text_we ? tix_reg + 5'd1 : tix_reg;
        txt_next = !rx_eoi;
      end
    end
  end
  assign text_idx = tix_reg;

  // Text registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tix_reg <= '0;
      txt_reg <= 1'b0;
    end else if (clk_en) begin
      tix_reg <= tix_next;
      txt_reg <= txt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing fifo gives back-pressure to the sequencer
  assign ob.data  = ob_data;
  assign ob.last  = ob_last;
  assign ob.valid = ob_valid;

  swt_fifo #(.WIDTH(9), .DEPTH(FIFO_D)) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   ({ob.last, ob.data}),
    .in_valid  (ob.valid),
    .in_ready  (ob.ready),
    .out_data  (f_out),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );
  assign tx_data = f_out[7:0];
  assign tx_eoi  = f_out[8];
endmodule : swt_engine // swt_engine
`default_nettype wire

// ==== test/swt_host_model.sv ====
// Controller model that reads talker bytes from the engine.
// Assumes it shares sys_clk and sys_rst with the engine.
`timescale 1ns/10ps
`default_nettype none
module swt_host_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Pacing, high reads every other cycle
  input  wire logic       slow,
  // Talker bytes
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eoi,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic       pace_reg;  // Toggles to throttle reads
  logic [8:0] got[$];    // Received {eoi, byte}, oldest first
  //////////////////////////////////////////////////////////////
  // Slow mode drops ready every other cycle to push back on the fifo
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pace_reg <= 1'b0;
    end else begin
      pace_reg <= ~pace_reg;
    end
  end
  assign tx_ready = ~slow | pace_reg;
  // Whole response is read before the next query goes out
  always @(posedge sys_clk) begin
    if (!sys_rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back({tx_eoi, tx_data});
    end
  end
endmodule // swt_host_model
`default_nettype wire

// ==== test/swt_engine_props.sv ====
// Port checker for the message engine.
// Assumes one clock domain and the synchronous reset of the engine.
`timescale 1ns/10ps
`default_nettype none
module swt_engine_props import swt_pkg::*; (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                clk_en,
  // Commands
  input wire swt_pkg::swt_cmd_t   cmd,
  input wire logic [4:0]          cmd_arg,
  input wire logic                cmd_valid,
  input wire logic                cmd_ready,
  // Talker
  input wire logic [7:0]          tx_data,
  input wire logic                tx_eoi,
  input wire logic                tx_valid,
  input wire logic                tx_ready,
  // Panel and status
  input wire logic [8:0]          panel_len,
  input wire logic                panel_load,
  input wire logic [4:0]          text_idx,
  input wire logic                text_we,
  input wire logic                store_mode,
  input wire logic                busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic take;  // Command accepted at this edge
  assign take = cmd_valid && cmd_ready && clk_en;
  //////////////////////////////////////////////////////////////
  rst_idle_a: assert property ($fell(sys_rst) |-> !tx_valid && cmd_ready && !busy && !store_mode)
    else $error("engine not idle after reset");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eoi))
    else $error("talker byte changed before taken");
  setq_first_a: assert property (take && cmd == SWT_CMD_SETQ && panel_len != 9'h000 |-> ##[2:3] tx_valid)
    else $error("setup reply late");
  store_set_a: assert property (take && cmd == SWT_CMD_STORE |-> ##[1:3] store_mode)
    else $error("store mode not entered");
  store_keep_a: assert property (store_mode |=> store_mode)
    else $error("store mode dropped");
  ready_busy_a: assert property (take && (cmd == SWT_CMD_SETQ || cmd == SWT_CMD_PREQ || cmd == SWT_CMD_HORQ
    || cmd == SWT_CMD_CURVQ) |=> busy && !cmd_ready)
    else $error("query not holding off further commands");
  bad_slot_a: assert property (take && (cmd == SWT_CMD_SAVE || cmd == SWT_CMD_RECL)
    && (cmd_arg == 5'h00 || cmd_arg > 5'h10) |=> !busy)
    else $error("bad slot number not ignored");
  load_busy_a: assert property (panel_load |-> busy)
    else $error("panel load while idle");
  text_bound_a: assert property (text_we |-> text_idx < 5'h18)
    else $error("text written past its area");
  // Main scenarios reached
  setq_c: cover property (take && cmd == SWT_CMD_SETQ);
  eoi_c: cover property (tx_valid && tx_ready && tx_eoi);
  load_c: cover property (panel_load);
endmodule // swt_engine_props
bind swt_engine swt_engine_props swt_engine_props_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cmd(cmd), .cmd_arg(cmd_arg),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .tx_data(tx_data), .tx_eoi(tx_eoi),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .panel_len(panel_len), .panel_load(panel_load),
  .text_idx(text_idx), .text_we(text_we), .store_mode(store_mode), .busy(busy));
`default_nettype wire

// ==== test/tb_swt_engine.sv ====
// Self-checking bench for the message engine.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_swt_engine;
  import swt_pkg::*;
  logic        sys_clk, sys_rst, clk_en, slow, rx_valid, rx_eoi, cmd_valid, cmd_ready;
  logic        tx_eoi, tx_valid, tx_ready, panel_load, text_we, store_mode, busy;
  logic [7:0]  rx_data, tx_data, panel_char, pre_char, hor_char, id_char, text_char;
  swt_cmd_t    cmd;
  logic [4:0]  cmd_arg, text_idx;
  logic [8:0]  panel_idx, panel_len, pre_len, hor_len, src_idx;
  logic [9:0]  pt_x, pt_y;
  logic [10:0] pt_count, pt_idx;
  logic [8:0]  exp_q[$];  // Expected {eoi, byte}
  int          fails, cmp_count, n_wr, load_seen;
  logic [12:0] last_txt;  // Last text write {index, char}
  //////////////////////////////////////////////////////////////
  swt_engine swt_engine_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_eoi(rx_eoi), .cmd(cmd), .cmd_arg(cmd_arg),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .tx_data(tx_data), .tx_eoi(tx_eoi),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .panel_char(panel_char), .panel_idx(panel_idx),
    .panel_len(panel_len), .panel_load(panel_load), .text_char(text_char), .text_idx(text_idx),
    .text_we(text_we), .store_mode(store_mode), .pre_char(pre_char), .pre_len(pre_len),
    .hor_char(hor_char), .hor_len(hor_len), .id_char(id_char), .pt_x(pt_x), .pt_y(pt_y),
    .pt_count(pt_count), .src_idx(src_idx), .pt_idx(pt_idx), .busy(busy));
  swt_host_model swt_host_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
    .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_valid(tx_valid), .tx_ready(tx_ready));
  // Sources answer in the same cycle; x is negative to exercise sign fill
  always_comb begin
    panel_char = 8'h20 + {2'b00, panel_idx[5:0]};
    pre_char = 8'h30 + {4'h0, src_idx[3:0]};
    hor_char = 8'h61 + {4'h0, src_idx[3:0]};
    id_char = 8'h41 + {3'b000, src_idx[4:0]};
    pt_x = {1'b1, pt_idx[8:0]};
    pt_y = {1'b0, pt_idx[8:0]} + 10'h005;
  end
  // Count text writes and flag any recall window
  always @(posedge sys_clk) begin
    if (text_we === 1'b1) n_wr <= n_wr + 1;
    if (text_we === 1'b1) last_txt <= {text_idx, text_char};
    if (panel_load === 1'b1) load_seen <= 1;
  end
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hold the command until ready is sampled high
  task automatic issue(input swt_cmd_t c, input logic [4:0] a);
    int k;
    k = 0;
    @(posedge sys_clk);
    cmd <= c;
    cmd_arg <= a;
    cmd_valid <= 1'b1;
    do begin @(posedge sys_clk); k++; end while (cmd_ready !== 1'b1 && k < 2000);
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (busy !== 1'b0 && k < 1000);
  endtask
  task automatic rx_send(input logic [7:0] b, input logic e);
    @(posedge sys_clk);
    rx_data <= b;
    rx_eoi <= e;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_eoi <= 1'b0;
  endtask
  // Query, read to the terminating byte, compare with exp_q
  task automatic run_resp(input string what, input swt_cmd_t c);
    int k;
    k = 0;
    swt_host_model_inst.got.delete();
    issue(c, 5'h00);
    while (k < 9000 && !(swt_host_model_inst.got.size() > 0 && swt_host_model_inst.got[$][8] === 1'b1)) begin
      @(posedge sys_clk);
      k++;
    end
    check({what, " length"}, 16'(swt_host_model_inst.got.size()), 16'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < swt_host_model_inst.got.size(); i++)
      check(what, 16'(swt_host_model_inst.got[i]), 16'(exp_q[i]));
  endtask
  //////////////////////////////////////////////////////////////
  // Longest setup image, slow reader
  task automatic t_setq();
    panel_len <= 9'h1F4;  // Longer than allowed, reply must clip to 400
    slow <= 1'b1;
    exp_q.delete();
    for (int i = 0; i < 400; i++) exp_q.push_back({i == 399, 8'h20 + 8'(i % 64)});
    run_resp("setup", SWT_CMD_SETQ);
  endtask
  task automatic t_ascii();
    slow <= 1'b0;
    hor_len <= 9'h01D;
    pre_len <= 9'h19A;
    exp_q.delete();
    for (int i = 0; i < 29; i++) exp_q.push_back({i == 28, 8'h61 + 8'(i % 16)});
    run_resp("horizontal", SWT_CMD_HORQ);
    exp_q.delete();
    for (int i = 0; i < 410; i++) exp_q.push_back({i == 409, 8'h30 + 8'(i % 16)});
    run_resp("preamble", SWT_CMD_PREQ);
  endtask
  // One point and the full 1024, the long one with back-pressure
  task automatic t_curve();
    logic [9:0]  c[2];
    logic [7:0]  b, sum;
    logic [15:0] cnt;
    int          n;
    for (int k = 0; k < 2; k++) begin
      n = (k == 0) ? 1 : 1024;
      pt_count <= 11'(n);
      slow <= k[0];
      exp_q.delete();
      for (int i = 0; i < 25; i++) exp_q.push_back({1'b0, 8'h41 + 8'(i)});
      cnt = 16'(4 * n);
      sum = cnt[15:8] + cnt[7:0];
      exp_q.push_back({1'b0, cnt[15:8]});
      exp_q.push_back({1'b0, cnt[7:0]});
      for (int j = 0; j < n; j++) begin
        c[0] = {1'b1, 9'(j)};
        c[1] = {1'b0, 9'(j)} + 10'h005;
        for (int m = 0; m < 2; m++) begin
          b = {{6{c[m][9]}}, c[m][9:8]};
          sum = sum + b + c[m][7:0];
          exp_q.push_back({1'b0, b});
          exp_q.push_back({1'b0, c[m][7:0]});
        end
      end
      exp_q.push_back({1'b1, sum});
      run_resp("curve", SWT_CMD_CURVQ);
    end
  endtask
  // Overlong text ended by the end line, then short text ended by line feed
  task automatic t_text();
    n_wr = 0;
    issue(SWT_CMD_TEXT, 5'h00);
    for (int i = 0; i < 26; i++) rx_send(8'h61 + 8'(i), i == 25);
    wait_idle();
    check("text writes", 16'(n_wr), 16'h0018);
    n_wr = 0;
    issue(SWT_CMD_TEXT, 5'h00);
    rx_send(8'h41, 1'b0);
    rx_send(8'h42, 1'b0);
    rx_send(CH_LF, 1'b0);
    wait_idle();
    #1 check("line feed text", {n_wr[14:0], busy}, 16'h0004);
    check("text char", 16'(last_txt), 16'h0142);
  endtask
  // Save with five frozen edges mid-copy, then recall and refused slots
  task automatic t_slots();
    int k;
    load_seen = 0;
    issue(SWT_CMD_SAVE, 5'h10);
    @(posedge sys_clk);
    #1 check("save busy", {15'h0000, busy}, 16'h0001);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    clk_en <= 1'b1;
    k = 7;
    do begin @(posedge sys_clk); k++; end while (busy !== 1'b0 && k < 1000);
    check("save cycles", 16'(k), 16'(SET_MAX_CHARS + 6));
    issue(SWT_CMD_RECL, 5'h10);
    wait_idle();
    check("recall load", 16'(load_seen), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      issue(i[0] ? SWT_CMD_RECL : SWT_CMD_SAVE, i[1] ? 5'h11 : 5'h00);
      @(posedge sys_clk);
      #1 check("bad slot", {15'h0000, busy}, 16'h0000);
    end
  endtask
  // Store mode sticks until a mid-run reset
  task automatic t_store();
    issue(SWT_CMD_STORE, 5'h00);
    wait_idle();
    #1 check("store mode", {15'h0000, store_mode}, 16'h0001);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1 check("store after reset", {14'h0000, store_mode, cmd_ready}, 16'h0001);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {slow, rx_valid, rx_eoi, cmd_valid, rx_data, cmd_arg} = '0;
    {panel_len, pre_len, hor_len, pt_count} = '0;
    cmd = SWT_CMD_NONE;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_setq();
    t_ascii();
    t_curve();
    t_text();
    t_slots();
    t_store();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule // tb_swt_engine
`default_nettype wire
